// ### eeprom_save_load_control_bench.sv
`timescale 1ns/10ps
module eeprom_save_load_control_bench;
   import nvm_ctrl_pkg::*;
   logic              mclk, rst_n, wr, rd, boot, status, soft_rst, go_ok;
   logic [ADDR_W-1:0] addr, act_addr;
   logic [DATA_W-1:0] wdata, rdata, act_data, got, lfsr;
   int                mismatches, n_compared, cycles, pulses;
   int                model_buf[8];
   int                model_nvm[8];
   logic [11:0]       ra[5] = '{PROGRESS_ADDR, ERROR_ADDR, RELOAD_WEN_ADDR, SAVE_ADDR, 12'h0b04};

   nvm_save_load_ctrl #(.BANK_DEPTH(64), .WR_CYCLES(1)) i_dut (
      .MCLK_IN(mclk), .RST_N_IN(rst_n), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
      .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .ACTIVE_ADDR_IN(act_addr),
      .ACTIVE_DATA_OUT(act_data), .BOOT_SEL_IN(boot), .STATUS_OUT(status),
      .SOFT_RESET_OUT(soft_rst));
   nvm_holdoff_model i_hold (.clk_in(mclk), .rst_n_in(rst_n), .busy_in(status), .go_ok_out(go_ok));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [11:0] a, output logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      @(posedge mclk);
      #1 d = rdata;
   endtask
   task automatic wait_idle();
      repeat (2) @(posedge mclk);
      for (int i = 0; i < 3000; i++) begin
         rd_reg(PROGRESS_ADDR, got);
         if (got[0] === 1'b0) break;
      end
      if (got[0] !== 1'b0) mismatches++;
   endtask
   task automatic wait_go();
      for (int i = 0; i < 3000 && go_ok !== 1'b1; i++) @(posedge mclk);
      if (go_ok !== 1'b1) mismatches++;
   endtask
   task automatic fill_buf();
      for (int i = 0; i < 8; i++) begin
         lfsr = lfsr_next(lfsr);
         model_buf[i] = lfsr;
         wr_reg(12'(i), lfsr);
      end
   endtask

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cycles++;
      if (soft_rst === 1'b1) pulses++;
      if (cycles == 20000) begin
         mismatches++;
         summarize();
      end
   end

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      {rst_n, wr, rd, addr, wdata, act_addr} = '0;
      boot = 1'b1;
      lfsr = 8'h34;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      foreach (ra[i]) begin
         rd_reg(ra[i], got);
         check(got, 8'h00);
      end
      rd_reg(LIST_BASE, got);
      check(got, DEF_CHUNK_LEN);
      rd_reg(LIST_BASE + 12'h018, got);
      check(got, OPC_COMMIT);
      rd_reg(LIST_BASE + 12'h019, got);
      check(got, OPC_END);
      lfsr = lfsr_next(lfsr);
      wr_reg(LIST_BASE + 12'h01a, lfsr);
      rd_reg(LIST_BASE + 12'h01a, got);
      check(got, lfsr);
      $display("reset values done");

      fill_buf();
      wr_reg(STATUS_CFG_ADDR, 8'h80);
      wr_reg(COMMIT_ADDR, 8'h01);
      repeat (70) @(posedge mclk);
      rd_reg(COMMIT_ADDR, got);
      check(got, 8'h00);
      wr_reg(RELOAD_WEN_ADDR, 8'h01);
      wr_reg(SAVE_ADDR, 8'h01);
      model_nvm = model_buf;
      repeat (2) @(posedge mclk);
      rd_reg(PROGRESS_ADDR, got);
      check(got, 8'h01);
      check({7'h0, status}, 8'h01);
      rd_reg(SAVE_ADDR, got);
      check(got, 8'h01);
      wait_idle();
      check({7'h0, status}, 8'h00);
      rd_reg(SAVE_ADDR, got);
      check(got, 8'h00);
      rd_reg(ERROR_ADDR, got);
      check(got, 8'h00);
      $display("save done");

      wait_go();
      fill_buf();
      wr_reg(RELOAD_WEN_ADDR, 8'h00);
      wr_reg(SAVE_ADDR, 8'h01);
      repeat (2) @(posedge mclk);
      rd_reg(PROGRESS_ADDR, got);
      check(got, 8'h00);
      rd_reg(SAVE_ADDR, got);
      check(got, 8'h00);
      wr_reg(RELOAD_WEN_ADDR, 8'h02);
      repeat (4) @(posedge mclk);
      rd_reg(PROGRESS_ADDR, got);
      check(got, 8'h00);
      check(8'(pulses), 8'h00);
      $display("blocked requests done");

      @(posedge mclk);
      boot <= 1'b0;
      repeat (4) @(posedge mclk);
      wr_reg(RELOAD_WEN_ADDR, 8'h02);
      wait_idle();
      repeat (4) @(posedge mclk);
      check(8'(pulses), 8'h01);
      rd_reg(RELOAD_WEN_ADDR, got);
      check(got, 8'h00);
      for (int i = 0; i < 8; i++) begin
         rd_reg(12'(i), got);
         check(got, 8'(model_nvm[i]));
         @(posedge mclk);
         act_addr <= 12'(i);
         repeat (2) @(posedge mclk);
         #1 check(act_data, 8'(model_nvm[i]));
      end
      $display("reload done");
      summarize();
   end
endmodule

// ### nvm_ctrl_pkg.sv
// How it works
// [RULE1] progress bit high while save/load runs
// [RULE2] status pin shows progress when selected
// [RULE3] error bit flags bad data on transfer
// [RULE4] boot-select low: reload bit reloads, self-clears
// [RULE5] write-enable bit gates saves, default blocked
// [RULE6] save bit starts save, clears when done
// [RULE7] host waits 10 us between transfers
// [RULE8] blocked save leaves storage unchanged
// [RULE9] list entry bit7 low: move, length, address
// [RULE10] bit7 high: commit or end opcode
// [RULE11] commit bit copies buffer to active, self-clears
package nvm_ctrl_pkg;
   localparam int          ADDR_W          = 12;
   localparam int          DATA_W          = 8;
   localparam logic [11:0] PROGRESS_ADDR   = 12'h0b00;
   localparam logic [11:0] ERROR_ADDR      = 12'h0b01;
   localparam logic [11:0] RELOAD_WEN_ADDR = 12'h0b02;
   localparam logic [11:0] SAVE_ADDR       = 12'h0b03;
   localparam logic [11:0] COMMIT_ADDR     = 12'h0232;
   localparam logic [11:0] STATUS_CFG_ADDR = 12'h001d;
   localparam logic [11:0] LIST_BASE       = 12'h0a00;
   localparam logic [11:0] LIST_LAST       = 12'h0aff;
   localparam int          PROGRESS_BIT    = 0;
   localparam int          ERROR_BIT       = 0;
   localparam int          WEN_BIT         = 0;
   localparam int          RELOAD_BIT      = 1;
   localparam int          SAVE_BIT        = 0;
   localparam int          COMMIT_BIT      = 0;
   localparam int          STATUS_SEL_BIT  = 7;
   localparam int          OPCODE_BIT      = 7;
   localparam logic [7:0]  OPC_COMMIT      = 8'h80;
   localparam logic [7:0]  OPC_END         = 8'hff;
   localparam logic [7:0]  DEF_CHUNK_LEN   = 8'h7f;
   localparam int          DEF_CHUNKS      = 8;
   localparam int          FIFO_DEPTH      = 32;
   localparam int          NVM_WR_CYCLES   = 4;
   localparam int          CLK_MHZ         = 100;
   localparam int          HOLDOFF_US      = 10;
   localparam int          HOLDOFF_CYCLES  = HOLDOFF_US * CLK_MHZ;

   typedef enum logic [6:0] {
      ST_IDLE    = 7'b000_0001,
      ST_FETCH   = 7'b000_0010,
      ST_ADDR_HI = 7'b000_0100,
      ST_ADDR_LO = 7'b000_1000,
      ST_MOVE    = 7'b001_0000,
      ST_COMMIT  = 7'b010_0000,
      ST_DONE    = 7'b100_0000
   } state_e;
endpackage

// ### nvm_ctrl_sva.sv
`timescale 1ns/10ps
module nvm_ctrl_sva
   import nvm_ctrl_pkg::*;
(
   input wire logic              MCLK_IN,
   input wire logic              RST_N_IN,
   input wire logic [ADDR_W-1:0] REG_ADDR_IN,
   input wire logic [DATA_W-1:0] REG_WDATA_IN,
   input wire logic              REG_WR_IN,
   input wire logic              REG_RD_IN,
   input wire logic [DATA_W-1:0] REG_RDATA_OUT,
   input wire logic              BOOT_SEL_IN,
   input wire logic              STATUS_OUT,
   input wire logic              SOFT_RESET_OUT
);
   logic wen_m;
   logic sv_arm;
   logic rl_arm;
   wire  wr_ctl = REG_WR_IN && REG_ADDR_IN == RELOAD_WEN_ADDR;
   wire  rl_go  = wr_ctl && REG_WDATA_IN[RELOAD_BIT] && !BOOT_SEL_IN;
   wire  sv_go  = REG_WR_IN && REG_ADDR_IN == SAVE_ADDR && REG_WDATA_IN[SAVE_BIT] && wen_m;

   default clocking cb @(posedge MCLK_IN); endclocking
   default disable iff (!RST_N_IN);

   // ----------------------------------------
   // request tracking
   // ----------------------------------------
   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         wen_m <= 1'b0;
      end else if (wr_ctl) begin
         wen_m <= REG_WDATA_IN[WEN_BIT];
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         sv_arm <= 1'b0;
      end else if (sv_go || rl_go) begin
         sv_arm <= 1'b1;
      end else if ($fell(STATUS_OUT)) begin
         sv_arm <= 1'b0;
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         rl_arm <= 1'b0;
      end else if (rl_go) begin
         rl_arm <= 1'b1;
      end else if (SOFT_RESET_OUT) begin
         rl_arm <= 1'b0;
      end
   end

   // ----------------------------------------
   // properties
   // ----------------------------------------
   sequence s_rd(logic [ADDR_W-1:0] a);
      REG_RD_IN && REG_ADDR_IN == a;
   endsequence

   a_rdata_hold: assert property (!REG_RD_IN && !$past(REG_RD_IN) |=> $stable(REG_RDATA_OUT))
      else $error("read data moved without a read");
   a_prog_unused: assert property (s_rd(PROGRESS_ADDR) |-> ##2 REG_RDATA_OUT[7:1] == 7'h0)
      else $error("progress register upper bits not zero");
   a_err_unused: assert property (s_rd(ERROR_ADDR) |-> ##2 REG_RDATA_OUT[7:1] == 7'h0)
      else $error("error register upper bits not zero");
   a_ctl_unused: assert property (s_rd(RELOAD_WEN_ADDR) |-> ##2 REG_RDATA_OUT[7:2] == 6'h0)
      else $error("control register upper bits not zero");
   a_save_unused: assert property (s_rd(SAVE_ADDR) |-> ##2 REG_RDATA_OUT[7:1] == 7'h0)
      else $error("save register upper bits not zero");
   a_gap_zero: assert property (s_rd(12'h0b04) |-> ##2 REG_RDATA_OUT == 8'h00)
      else $error("unmapped read not zero");
   a_soft_pulse: assert property (SOFT_RESET_OUT |=> !SOFT_RESET_OUT)
      else $error("soft reset longer than one cycle");
   a_soft_needs_req: assert property (SOFT_RESET_OUT |-> rl_arm)
      else $error("soft reset without allowed reload request");
   a_busy_needs_req: assert property ($rose(STATUS_OUT) |-> sv_arm)
      else $error("transfer started without allowed request");
endmodule

bind nvm_save_load_ctrl nvm_ctrl_sva i_sva (
   .MCLK_IN        (MCLK_IN),
   .RST_N_IN       (RST_N_IN),
   .REG_ADDR_IN    (REG_ADDR_IN),
   .REG_WDATA_IN   (REG_WDATA_IN),
   .REG_WR_IN      (REG_WR_IN),
   .REG_RD_IN      (REG_RD_IN),
   .REG_RDATA_OUT  (REG_RDATA_OUT),
   .BOOT_SEL_IN    (BOOT_SEL_IN),
   .STATUS_OUT     (STATUS_OUT),
   .SOFT_RESET_OUT (SOFT_RESET_OUT)
);

// ### nvm_holdoff_model.sv
`timescale 1ns/10ps
module nvm_holdoff_model
   import nvm_ctrl_pkg::*;
(
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic busy_in,
   output logic      go_ok_out
);
   int cnt;

   // ----------------------------------------
   // quiet gap after each transfer
   // ----------------------------------------
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || busy_in) begin
         cnt <= 0;
      end else if (cnt < HOLDOFF_CYCLES) begin
         cnt <= cnt + 1;
      end
   end

   assign go_ok_out = (cnt >= HOLDOFF_CYCLES);
endmodule

// ### nvm_save_load_ctrl.sv
`timescale 1ns/10ps
module nvm_save_load_ctrl #(
   parameter int BANK_DEPTH = 1024,
   parameter int NVM_DEPTH  = 2048,
   parameter int WR_CYCLES  = nvm_ctrl_pkg::NVM_WR_CYCLES
) (
   input  wire logic                             MCLK_IN,
   input  wire logic                             RST_N_IN,
   input  wire logic [nvm_ctrl_pkg::ADDR_W-1:0]  REG_ADDR_IN,
   input  wire logic [nvm_ctrl_pkg::DATA_W-1:0]  REG_WDATA_IN,
   input  wire logic                             REG_WR_IN,
   input  wire logic                             REG_RD_IN,
   output logic      [nvm_ctrl_pkg::DATA_W-1:0]  REG_RDATA_OUT,
   input  wire logic [nvm_ctrl_pkg::ADDR_W-1:0]  ACTIVE_ADDR_IN,
   output logic      [nvm_ctrl_pkg::DATA_W-1:0]  ACTIVE_DATA_OUT,
   input  wire logic                             BOOT_SEL_IN,
   output logic                                  STATUS_OUT,
   output logic                                  SOFT_RESET_OUT
);
   import nvm_ctrl_pkg::*;

   localparam int BW = $clog2(BANK_DEPTH);
   localparam int NW = $clog2(NVM_DEPTH);
   localparam int TW = $clog2(WR_CYCLES + 1);

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   logic [7:0] bank   [BANK_DEPTH];
   logic [7:0] active [BANK_DEPTH];
   logic [7:0] tlist  [256];
   logic [8:0] nvm    [NVM_DEPTH];

   state_e      state;
   logic [7:0]  list_idx;
   logic        mode_load;
   logic        commit_only;
   logic [7:0]  move_len;
   logic [11:0] move_addr;
   logic [NW-1:0] nvm_base;
   logic [8:0]  src_cnt;
   logic [8:0]  dst_cnt;
   logic [BW-1:0] commit_idx;
   logic        wen;
   logic        save_go;
   logic        reload_go;
   logic        data_err;
   logic        commit_go;
   logic        boot_meta;
   logic        boot_sync;
   logic [TW-1:0] wr_timer;
   logic        nvm_tick;
   logic [7:0]  entry;
   logic        busy;

   logic        host_wr_bank;
   logic        src_valid;
   logic        src_ready;
   logic [8:0]  src_word;
   logic        snk_valid;
   logic        snk_ready;
   logic [8:0]  snk_word;
   logic        pop;
   logic [BW-1:0] src_bidx;
   logic [BW-1:0] dst_bidx;

   assign entry        = tlist[list_idx];
   assign busy         = (state != ST_IDLE) && !commit_only;
   assign host_wr_bank = REG_WR_IN && (REG_ADDR_IN < 12'(BANK_DEPTH))
                         && (REG_ADDR_IN != COMMIT_ADDR);
   assign src_bidx     = BW'(move_addr + {3'h0, src_cnt});
   assign dst_bidx     = BW'(move_addr + {3'h0, dst_cnt});

   // ----------------------------------------------------------------
   // boot-select pin synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         boot_meta <= 1'b1;
         boot_sync <= 1'b1;
      end else begin
         boot_meta <= BOOT_SEL_IN;
         boot_sync <= boot_meta;
      end
   end

   // ----------------------------------------------------------------
   // storage write pacing (enable pulse)
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN || state != ST_MOVE) begin
         wr_timer <= '0;
      end else if (wr_timer == TW'(WR_CYCLES - 1)) begin
         wr_timer <= '0;
      end else begin
         wr_timer <= wr_timer + 1'b1;
      end
   end
   assign nvm_tick = (state == ST_MOVE) && (wr_timer == TW'(WR_CYCLES - 1));

   // ----------------------------------------------------------------
   // data stream through the fifo
   // ----------------------------------------------------------------
   assign src_valid = (state == ST_MOVE) && (src_cnt <= {1'b0, move_len});
   assign src_word  = mode_load ? nvm[NW'(nvm_base + NW'(src_cnt))]
                                : {^bank[src_bidx], bank[src_bidx]};
   assign snk_ready = (state == ST_MOVE) && (mode_load || nvm_tick);
   assign pop       = snk_valid && snk_ready;

   nvm_stream_fifo #(
      .WIDTH (9),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_in        (MCLK_IN),
      .rst_n_in      (RST_N_IN),
      .in_valid_in   (src_valid),
      .in_ready_out  (src_ready),
      .in_data_in    (src_word),
      .out_valid_out (snk_valid),
      .out_ready_in  (snk_ready),
      .out_data_out  (snk_word)
   );

   // ----------------------------------------------------------------
   // nonvolatile array, parity kept with each byte
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK_IN) begin
      if (pop && !mode_load) begin
         nvm[NW'(nvm_base + NW'(dst_cnt))] <= snk_word;
      end
   end

   // ----------------------------------------------------------------
   // buffer bank: engine load has priority over host writes
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK_IN) begin
      if (pop && mode_load) begin
         bank[dst_bidx] <= snk_word[7:0];
      end else if (host_wr_bank) begin
         bank[BW'(REG_ADDR_IN)] <= REG_WDATA_IN;
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (state == ST_COMMIT) begin
         active[commit_idx] <= bank[commit_idx];                   // see [RULE11]
      end
   end

   // ----------------------------------------------------------------
   // transfer list, default walks the whole bank then commits
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         for (int i = 0; i < 256; i++) begin
            if (i < 3 * DEF_CHUNKS) begin
               unique case (i % 3)
                  0: tlist[i] <= DEF_CHUNK_LEN;
                  1: tlist[i] <= 8'((i / 3) * 128 / 256);
                  2: tlist[i] <= 8'((i / 3) * 128);
               endcase
            end else if (i == 3 * DEF_CHUNKS) begin
               tlist[i] <= OPC_COMMIT;
            end else begin
               tlist[i] <= OPC_END;
            end
         end
      end else if (REG_WR_IN && REG_ADDR_IN >= LIST_BASE && REG_ADDR_IN <= LIST_LAST) begin
         tlist[REG_ADDR_IN[7:0]] <= REG_WDATA_IN;
      end
   end

   // ----------------------------------------------------------------
   // control bits
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         wen <= 1'b0;                                              // see [RULE5]
      end else if (REG_WR_IN && REG_ADDR_IN == RELOAD_WEN_ADDR) begin
         wen <= REG_WDATA_IN[WEN_BIT];
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         save_go <= 1'b0;
      end else if (state == ST_IDLE && save_go && !wen) begin
         save_go <= 1'b0;                                          // see [RULE8]
      end else if (state == ST_DONE && !mode_load) begin
         save_go <= 1'b0;                                          // see [RULE6]
      end else if (REG_WR_IN && REG_ADDR_IN == SAVE_ADDR && REG_WDATA_IN[SAVE_BIT]
                   && state == ST_IDLE) begin
         save_go <= 1'b1;                                          // see [RULE6]
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         reload_go <= 1'b0;
      end else if (state == ST_DONE && mode_load) begin
         reload_go <= 1'b0;                                        // see [RULE4]
      end else if (REG_WR_IN && REG_ADDR_IN == RELOAD_WEN_ADDR
                   && REG_WDATA_IN[RELOAD_BIT] && !boot_sync && state == ST_IDLE) begin
         reload_go <= 1'b1;                                        // see [RULE4]
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         commit_go <= 1'b0;
      end else if (REG_WR_IN && REG_ADDR_IN == COMMIT_ADDR && REG_WDATA_IN[COMMIT_BIT]) begin
         commit_go <= 1'b1;
      end else if (state == ST_COMMIT && commit_only) begin
         commit_go <= 1'b0;                                        // see [RULE11]
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         data_err <= 1'b0;
      end else if (pop && mode_load && (^snk_word)) begin
         data_err <= 1'b1;                                         // see [RULE3]
      end else if (state == ST_IDLE && (reload_go || (save_go && wen))) begin
         data_err <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // transfer engine
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         state       <= ST_IDLE;
         list_idx    <= '0;
         mode_load   <= 1'b0;
         commit_only <= 1'b0;
         move_len    <= '0;
         move_addr   <= '0;
         nvm_base    <= '0;
         src_cnt     <= '0;
         dst_cnt     <= '0;
         commit_idx  <= '0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               list_idx <= '0;
               nvm_base <= '0;
               if (reload_go) begin
                  mode_load <= 1'b1;
                  state     <= ST_FETCH;
               end else if (save_go && wen) begin
                  mode_load <= 1'b0;
                  state     <= ST_FETCH;
               end else if (commit_go) begin
                  commit_only <= 1'b1;
                  commit_idx  <= '0;
                  state       <= ST_COMMIT;
               end
            end
            ST_FETCH: begin
               list_idx <= list_idx + 1'b1;
               if (!entry[OPCODE_BIT]) begin
                  move_len <= entry;                               // see [RULE9]
                  state    <= ST_ADDR_HI;
               end else if (entry == OPC_COMMIT) begin
                  commit_idx <= '0;                                // see [RULE10]
                  state      <= ST_COMMIT;
               end else begin
                  state <= ST_DONE;                                // see [RULE10]
               end
            end
            ST_ADDR_HI: begin
               move_addr[11:8] <= entry[3:0];                      // see [RULE9]
               list_idx        <= list_idx + 1'b1;
               state           <= ST_ADDR_LO;
            end
            ST_ADDR_LO: begin
               move_addr[7:0] <= entry;
               list_idx       <= list_idx + 1'b1;
               src_cnt        <= '0;
               dst_cnt        <= '0;
               state          <= ST_MOVE;
            end
            ST_MOVE: begin
               if (src_valid && src_ready) begin
                  src_cnt <= src_cnt + 1'b1;
               end
               if (pop) begin
                  dst_cnt <= dst_cnt + 1'b1;
                  if (dst_cnt == {1'b0, move_len}) begin
                     nvm_base <= NW'(nvm_base + NW'(move_len) + 1'b1);
                     state    <= ST_FETCH;
                  end
               end
            end
            ST_COMMIT: begin
               commit_idx <= commit_idx + 1'b1;
               if (commit_idx == BW'(BANK_DEPTH - 1)) begin
                  state       <= commit_only ? ST_IDLE : ST_FETCH;
                  commit_only <= 1'b0;
               end
            end
            ST_DONE: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // outputs and register reads
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         STATUS_OUT     <= 1'b0;
         SOFT_RESET_OUT <= 1'b0;
      end else begin
         STATUS_OUT     <= busy && active[BW'(STATUS_CFG_ADDR)][STATUS_SEL_BIT]; // see [RULE2]
         SOFT_RESET_OUT <= (state == ST_DONE) && mode_load;       // see [RULE4]
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         ACTIVE_DATA_OUT <= '0;
      end else begin
         ACTIVE_DATA_OUT <= active[BW'(ACTIVE_ADDR_IN)];
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         REG_RDATA_OUT <= '0;
      end else if (REG_RD_IN) begin
         REG_RDATA_OUT <= '0;
         if (REG_ADDR_IN == PROGRESS_ADDR) begin
            REG_RDATA_OUT[PROGRESS_BIT] <= busy;                   // see [RULE1]
         end else if (REG_ADDR_IN == ERROR_ADDR) begin
            REG_RDATA_OUT[ERROR_BIT] <= data_err;                  // see [RULE3]
         end else if (REG_ADDR_IN == RELOAD_WEN_ADDR) begin
            REG_RDATA_OUT[WEN_BIT]    <= wen;
            REG_RDATA_OUT[RELOAD_BIT] <= reload_go;
         end else if (REG_ADDR_IN == SAVE_ADDR) begin
            REG_RDATA_OUT[SAVE_BIT] <= save_go;
         end else if (REG_ADDR_IN == COMMIT_ADDR) begin
            REG_RDATA_OUT[COMMIT_BIT] <= commit_go;
         end else if (REG_ADDR_IN >= LIST_BASE && REG_ADDR_IN <= LIST_LAST) begin
            REG_RDATA_OUT <= tlist[REG_ADDR_IN[7:0]];
         end else if (REG_ADDR_IN < 12'(BANK_DEPTH)) begin
            REG_RDATA_OUT <= bank[BW'(REG_ADDR_IN)];
         end
      end
   end
endmodule

// ### nvm_stream_fifo.sv
`timescale 1ns/10ps
module nvm_stream_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 32
) (
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   assign in_ready_out  = (count != (AW+1)'(DEPTH));
   assign out_valid_out = (count != '0);
   assign push          = in_valid_in & in_ready_out;
   assign pop           = out_valid_out & out_ready_in;
   assign out_data_out  = mem[rd_ptr];

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[wr_ptr] <= in_data_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
